// file: design/txifc_defs.svh
// register offsets, field positions, reset values and limits of the tx fir block
// assumes an 8-bit register address and 32-bit register data
`ifndef TXIFC_DEFS_SVH
`define TXIFC_DEFS_SVH
`define TXIFC_OFS_CTRL 8'h00
`define TXIFC_OFS_RATE 8'h04
`define TXIFC_OFS_CADDR 8'h08
`define TXIFC_OFS_CDATA 8'h0C
`define TXIFC_OFS_STATUS 8'h10
`define TXIFC_CTRL_INTERP_LSB 0
`define TXIFC_CTRL_TAPS_LSB 3
`define TXIFC_CTRL_GAIN_LSB 5
`define TXIFC_CTRL_HB1_LSB 7
`define TXIFC_CTRL_HB2_LSB 9
`define TXIFC_CTRL_HB3_LSB 11
`define TXIFC_CTRL_FIVE_LSB 13
`define TXIFC_CTRL_DIV5_BIT 16
`define TXIFC_CTRL_RESET 32'h00002AA0
`define TXIFC_RATE_RESET 19'h78000
`define TXIFC_RATE_MIN_KHZ 19'h07800
`define TXIFC_RATE_MAX_KHZ 19'h78000
`define TXIFC_DPROC_CLK_MAX_KHZ 32'h000F4240
`define TXIFC_TAP_UNIT 32'h00000014
`define TXIFC_HB_BYPASS 2'h1
`define TXIFC_HB_IN_USE 2'h2
`define TXIFC_FIVE_BYPASS 3'h1
`define TXIFC_FIVE_IN_USE 3'h5
`define TXIFC_HB3_COEFS 20'h14641
`define TXIFC_SCALE_SHIFT 15
`define TXIFC_SAT_MAX 16'h7FFF
`define TXIFC_SAT_MIN 16'h8000
`endif

// file: design/txifc_pkg.sv
// types shared by the tx fir block
// assumes nothing beyond a systemverilog compiler
package txifc_pkg;
    typedef enum logic [1:0] {
        TXIFC_IDLE,
        TXIFC_MAC,
        TXIFC_OUT
    } txifc_state_t;
    // gain select encoding: +6 dB, 0 dB, -6 dB, -12 dB
    typedef enum logic [1:0] {
        TXIFC_GAIN_P6,
        TXIFC_GAIN_0,
        TXIFC_GAIN_M6,
        TXIFC_GAIN_M12
    } txifc_gain_t;
endpackage

// file: design/txifc_coef_mem.sv
// coefficient store for the tx fir, one write port and one registered read port
// assumes write and read come from the same clock domain
`timescale 1ns/1ps
module txifc_coef_mem #(
    parameter int DEPTH = 80,
    parameter int AW = 7,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic signed [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    // addresses past the end are dropped so a runaway pointer cannot alias
    always_ff @(posedge clk) begin
        if (we && (32'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    // read data come from a register, one cycle after the address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= (32'(raddr) < DEPTH) ? signed'(mem[raddr]) : '0;
        end
    end
endmodule

// file: design/txifc_fir.sv
// programmable interpolating tx fir with settings for the following fixed stages
// assumes the deframer and the dac-side consumer run on CLOCK; registers via a plain port
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "txifc_defs.svh"

module txifc_fir #(
    parameter int MAX_TAPS = 80,
    parameter int DW = 16,
    parameter int AW = 40
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [DW-1:0] IN_I,
    input wire logic [DW-1:0] IN_Q,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [DW-1:0] OUT_I,
    output logic [DW-1:0] OUT_Q,
    output logic HB1_INTERP_EN,
    output logic HB2_INTERP_EN,
    output logic HB3_INTERP_EN,
    output logic FIVE_INTERP_EN,
    output logic DP_CLK_DIV5,
    output logic [19:0] HB3_COEF_TABLE
);
    txifc_pkg::txifc_state_t state_q;
    logic [31:0] ctrl_q;
    logic [18:0] rate_q;
    logic [6:0] caddr_q;
    logic sat_flag_q, byp_q, in_ready_q, pend_q;
    logic [2:0] phase_q, fir_l;
    logic [6:0] k_q, j_q, jd_q, ntaps;
    logic signed [AW-1:0] acc_i_q, acc_q_q;
    logic signed [DW-1:0] hist_i [MAX_TAPS];
    logic signed [DW-1:0] hist_q [MAX_TAPS];
    logic signed [DW-1:0] coef;
    logic signed [2*DW-1:0] prod_i, prod_q;
    logic [DW-1:0] b0_i_q, b0_q_q, b1_i_q, b1_q_q, new_i, new_q;
    logic [1:0] cnt_q, cnt_d, gain_sel;
    logic accept, rd_en, push, pop, sat_evt, conflict, over_taps, rate_bad, cfg_bad;
    logic hb1_on, hb2_on, hb3_on, five_on, cw_en;
    logic [16:0] res_i, res_q;
    logic [31:0] tap_load;

    // field decode; an illegal interpolation code is treated as bypass and flagged
    assign gain_sel = ctrl_q[`TXIFC_CTRL_GAIN_LSB +: 2];
    assign hb1_on = ctrl_q[`TXIFC_CTRL_HB1_LSB +: 2] == `TXIFC_HB_IN_USE;
    assign hb2_on = ctrl_q[`TXIFC_CTRL_HB2_LSB +: 2] == `TXIFC_HB_IN_USE;
    assign hb3_on = ctrl_q[`TXIFC_CTRL_HB3_LSB +: 2] == `TXIFC_HB_IN_USE;
    assign five_on = ctrl_q[`TXIFC_CTRL_FIVE_LSB +: 3] == `TXIFC_FIVE_IN_USE;
    assign conflict = five_on && (hb2_on || hb3_on);
    always_comb begin
        fir_l = ctrl_q[`TXIFC_CTRL_INTERP_LSB +: 3];
        cfg_bad = 1'h0;
        unique case (fir_l)
            3'h0, 3'h1, 3'h2, 3'h4: cfg_bad = 1'h0;
            default: begin
                fir_l = 3'h0;
                cfg_bad = 1'h1;
            end
        endcase
        unique case (ctrl_q[`TXIFC_CTRL_TAPS_LSB +: 2])
            2'h0: ntaps = 7'h14;
            2'h1: ntaps = 7'h28;
            2'h2: ntaps = 7'h3C;
            2'h3: ntaps = 7'h50;
        endcase
    end

    // taps times input rate must fit 20 taps per clock ratio at 1 GHz
    assign tap_load = 32'(ntaps) * 32'(rate_q);
    assign over_taps = tap_load > `TXIFC_DPROC_CLK_MAX_KHZ * `TXIFC_TAP_UNIT;
    assign rate_bad = (rate_q < `TXIFC_RATE_MIN_KHZ) || (rate_q > `TXIFC_RATE_MAX_KHZ);

    // software-written registers; coefficient pointer steps on each data write
    assign cw_en = REG_WR && (REG_ADDR == `TXIFC_OFS_CDATA);
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= `TXIFC_CTRL_RESET;
            rate_q <= `TXIFC_RATE_RESET;
            caddr_q <= 7'h00;
        end else if (REG_WR) begin
            if (REG_ADDR == `TXIFC_OFS_CTRL) ctrl_q <= {15'h0000, REG_WDATA[16:0]};
            if (REG_ADDR == `TXIFC_OFS_RATE) rate_q <= REG_WDATA[18:0];
            if (REG_ADDR == `TXIFC_OFS_CADDR) caddr_q <= REG_WDATA[6:0];
            if (cw_en) caddr_q <= caddr_q + 7'h01;
        end
    end

    // sticky saturation flag; a new event beats a write-one clear in the same cycle
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            sat_flag_q <= 1'h0;
        end else if (sat_evt) begin
            sat_flag_q <= 1'h1;
        end else if (REG_WR && REG_ADDR == `TXIFC_OFS_STATUS && REG_WDATA[0]) begin
            sat_flag_q <= 1'h0;
        end
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 32'h00000000;
        end else if (!REG_RD) begin
            REG_RDATA <= 32'h00000000;
        end else begin
            unique case (REG_ADDR)
                `TXIFC_OFS_CTRL: REG_RDATA <= ctrl_q;
                `TXIFC_OFS_RATE: REG_RDATA <= {13'h0000, rate_q};
                `TXIFC_OFS_CADDR: REG_RDATA <= {25'h0000000, caddr_q};
                `TXIFC_OFS_STATUS: REG_RDATA <= {26'h0000000, state_q != txifc_pkg::TXIFC_IDLE,
                    rate_bad, cfg_bad, over_taps, conflict, sat_flag_q};
                default: REG_RDATA <= 32'h00000000;
            endcase
        end
    end

    // settings handed to the fixed stages; five-fold wins over the second and third half-bands
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            HB1_INTERP_EN <= 1'h0;
            HB2_INTERP_EN <= 1'h0;
            HB3_INTERP_EN <= 1'h0;
            FIVE_INTERP_EN <= 1'h0;
            DP_CLK_DIV5 <= 1'h0;
            HB3_COEF_TABLE <= 20'h00000;
        end else begin
            HB1_INTERP_EN <= hb1_on;
            HB2_INTERP_EN <= hb2_on && !five_on;
            HB3_INTERP_EN <= hb3_on && !five_on;
            FIVE_INTERP_EN <= five_on;
            DP_CLK_DIV5 <= ctrl_q[`TXIFC_CTRL_DIV5_BIT];
            HB3_COEF_TABLE <= `TXIFC_HB3_COEFS; // eighths, outer tap first
        end
    end

    // coefficient fetch: address in one cycle, product in the next
    assign rd_en = (state_q == txifc_pkg::TXIFC_MAC) && (k_q < ntaps);
    txifc_coef_mem #(.DEPTH(MAX_TAPS), .AW(7), .DW(DW)) u_coef (
        .clk(CLOCK),
        .rstn(RSTN),
        .we(cw_en),
        .waddr(caddr_q),
        .wdata(REG_WDATA[DW-1:0]),
        .re(rd_en),
        .raddr(k_q),
        .rdata(coef)
    );
    assign prod_i = coef * hist_i[jd_q];
    assign prod_q = coef * hist_q[jd_q];

    // scale by 1/(2^15-1) via a two-term series, apply gain, clamp to 16 bits
    function automatic logic [16:0] txifc_scale(input logic signed [AW-1:0] a,
                                                 input logic [1:0] g);
        logic signed [AW-1:0] t;
        t = a + (a >>> `TXIFC_SCALE_SHIFT);
        t = t >>> `TXIFC_SCALE_SHIFT;
        unique case (g)
            txifc_pkg::TXIFC_GAIN_P6: t = t <<< 1;
            txifc_pkg::TXIFC_GAIN_0: t = t;
            txifc_pkg::TXIFC_GAIN_M6: t = t >>> 1;
            txifc_pkg::TXIFC_GAIN_M12: t = t >>> 2;
        endcase
        if (t > AW'(signed'(`TXIFC_SAT_MAX))) return {1'h1, `TXIFC_SAT_MAX};
        if (t < AW'(signed'(`TXIFC_SAT_MIN))) return {1'h1, `TXIFC_SAT_MIN};
        return {1'h0, t[DW-1:0]};
    endfunction

    always_comb begin
        res_i = txifc_scale(acc_i_q, gain_sel);
        res_q = txifc_scale(acc_q_q, gain_sel);
        new_i = byp_q ? hist_i[0] : res_i[DW-1:0];
        new_q = byp_q ? hist_q[0] : res_q[DW-1:0];
    end
    assign accept = IN_VALID && in_ready_q;
    assign push = (state_q == txifc_pkg::TXIFC_OUT) && (cnt_q != 2'h2);
    assign sat_evt = push && !byp_q && (res_i[16] || res_q[16]);

    // sample history; newest sample sits at index 0
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            for (int n = 0; n < MAX_TAPS; n++) begin
                hist_i[n] <= '0;
                hist_q[n] <= '0;
            end
        end else if (accept) begin
            hist_i[0] <= signed'(IN_I);
            hist_q[0] <= signed'(IN_Q);
            for (int n = 1; n < MAX_TAPS; n++) begin
                hist_i[n] <= hist_i[n-1];
                hist_q[n] <= hist_q[n-1];
            end
        end
    end

    // sequencer: per input, L output phases, phase p sums taps p, p+L, p+2L ...
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= txifc_pkg::TXIFC_IDLE;
            in_ready_q <= 1'h0;
            byp_q <= 1'h0;
            phase_q <= 3'h0;
            k_q <= 7'h00;
            j_q <= 7'h00;
            jd_q <= 7'h00;
            pend_q <= 1'h0;
            acc_i_q <= '0;
            acc_q_q <= '0;
        end else begin
            unique case (state_q)
                txifc_pkg::TXIFC_IDLE: begin
                    in_ready_q <= !accept;
                    if (accept) begin
                        byp_q <= fir_l == 3'h0;
                        phase_q <= 3'h0;
                        k_q <= 7'h00;
                        j_q <= 7'h00;
                        acc_i_q <= '0;
                        acc_q_q <= '0;
                        state_q <= (fir_l == 3'h0) ? txifc_pkg::TXIFC_OUT : txifc_pkg::TXIFC_MAC;
                    end
                end
                txifc_pkg::TXIFC_MAC: begin
                    pend_q <= rd_en;
                    if (rd_en) begin
                        k_q <= k_q + 7'(fir_l);
                        j_q <= j_q + 7'h01;
                        jd_q <= j_q;
                    end
                    if (pend_q) begin
                        acc_i_q <= acc_i_q + AW'(prod_i);
                        acc_q_q <= acc_q_q + AW'(prod_q);
                    end
                    if (!rd_en && !pend_q) state_q <= txifc_pkg::TXIFC_OUT;
                end
                txifc_pkg::TXIFC_OUT: begin
                    if (push) begin
                        // one output per phase keeps the output at the profile iq rate
                        if (byp_q || (phase_q + 3'h1 >= fir_l)) begin
                            state_q <= txifc_pkg::TXIFC_IDLE;
                            in_ready_q <= 1'h1;
                        end else begin
                            phase_q <= phase_q + 3'h1;
                            k_q <= 7'(phase_q + 3'h1);
                            j_q <= 7'h00;
                            acc_i_q <= '0;
                            acc_q_q <= '0;
                            state_q <= txifc_pkg::TXIFC_MAC;
                        end
                    end
                end
                default: state_q <= txifc_pkg::TXIFC_IDLE;
            endcase
        end
    end
    assign IN_READY = in_ready_q;

    // two-entry output buffer: a dac stall holds the sequencer, no word is lost
    assign pop = OUT_VALID && OUT_READY;
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) cnt_d = cnt_q + 2'h1;
        if (pop && !push) cnt_d = cnt_q - 2'h1;
    end
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_q <= 2'h0;
            OUT_VALID <= 1'h0;
            b0_i_q <= '0;
            b0_q_q <= '0;
            b1_i_q <= '0;
            b1_q_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            OUT_VALID <= cnt_d != 2'h0;
            if (pop) begin
                b0_i_q <= b1_i_q;
                b0_q_q <= b1_q_q;
            end
            if (push && (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))) begin
                b0_i_q <= new_i;
                b0_q_q <= new_q;
            end else if (push) begin
                b1_i_q <= new_i;
                b1_q_q <= new_q;
            end
        end
    end
    assign OUT_I = b0_i_q;
    assign OUT_Q = b0_q_q;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    chk_sat_clamp: assert property (sat_evt && res_i[16] |->
        new_i == `TXIFC_SAT_MAX || new_i == `TXIFC_SAT_MIN)
        else $error("saturated i result is not an extreme code");
    chk_mode_excl: assert property (FIVE_INTERP_EN |-> !HB2_INTERP_EN && !HB3_INTERP_EN)
        else $error("five-fold stage enabled with a half-band");
    chk_tap_bound: assert property (rd_en |-> k_q < 7'h50 && k_q < ntaps)
        else $error("coefficient fetched beyond tap count");
    chk_phase_count: assert property (push && !byp_q |-> phase_q < fir_l)
        else $error("more output phases than the interpolation factor");
    chk_bypass_pass: assert property (push && byp_q |=>
        (cnt_q == 2'h1 && !$past(pop)) |-> OUT_I == $past(hist_i[0]))
        else $error("bypassed sample changed");
    chk_hb_setting: assert property (##1 HB1_INTERP_EN ==
        ($past(ctrl_q[`TXIFC_CTRL_HB1_LSB +: 2]) == `TXIFC_HB_IN_USE))
        else $error("half-band enable does not follow its setting");
    chk_five_setting: assert property (##1 FIVE_INTERP_EN ==
        ($past(ctrl_q[`TXIFC_CTRL_FIVE_LSB +: 3]) == `TXIFC_FIVE_IN_USE))
        else $error("five-fold enable does not follow its setting");
    chk_clk_div: assert property (##1 DP_CLK_DIV5 == $past(ctrl_q[`TXIFC_CTRL_DIV5_BIT]))
        else $error("clock divider select not passed on");
    chk_buf_full: assert property (cnt_q == 2'h2 && !OUT_READY |=> cnt_q == 2'h2 && !push)
        else $error("output buffer overfilled");
    cov_bypass: cover property (push && byp_q);
    cov_interp4: cover property (push && fir_l == 3'h4 && phase_q == 3'h3);
    cov_buf_full: cover property (cnt_q == 2'h2 && !OUT_READY);
endmodule

// file: tb/txifc_src_model.sv
// deframer stand-in: hands one i/q sample at a time to the tx fir
// assumes the fir samples IN_VALID and IN_READY on the rising edge of the shared clock
`timescale 1ns/1ps
module txifc_src_model (
    input wire logic clk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [15:0] in_i,
    output logic [15:0] in_q
);
    int sent = 0;
    initial begin
        in_valid = 1'b0;
        in_i = 16'h0000;
        in_q = 16'h0000;
    end
    // idle lines toggle so that a stale sample is never mistaken for a fresh one
    task automatic send(input logic [15:0] i, input logic [15:0] q, input int gap);
        repeat (gap) begin
            @(posedge clk);
            in_i <= ~in_i;
            in_q <= ~in_q;
        end
        @(posedge clk);
        in_valid <= 1'b1;
        in_i <= i;
        in_q <= q;
        do @(posedge clk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        in_i <= ~i;
        in_q <= ~q;
        sent++;
    endtask
endmodule

// file: tb/txifc_fir_tb.sv
// self-checking bench for the tx fir: register port, sample stream, stage settings
// assumes the design files and the source model are compiled first
`timescale 1ns/1ps
`include "txifc_defs.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module txifc_fir_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic in_valid, in_ready, out_valid;
    logic out_ready = 1'b1;
    logic [15:0] in_i, in_q, out_i, out_q;
    logic [19:0] hb3_tab;
    logic [4:0] en; // hb1, hb2, hb3, five-fold, div5
    int failures = 0;
    int total_checks = 0;
    int seed = 32'h5c2e3e47;
    int rdy_mode = 0; // 0 ready, 1 random stalls, 2 held off
    logic [31:0] outq[$];
    logic signed [15:0] cf[80];
    logic signed [15:0] xi[$];
    logic signed [15:0] xq[$];

    always #4 clock = ~clock;

    txifc_fir txifc_fir_inst (.CLOCK(clock), .RSTN(rstn), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .IN_VALID(in_valid), .IN_READY(in_ready), .IN_I(in_i), .IN_Q(in_q),
        .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_I(out_i), .OUT_Q(out_q),
        .HB1_INTERP_EN(en[4]), .HB2_INTERP_EN(en[3]), .HB3_INTERP_EN(en[2]),
        .FIVE_INTERP_EN(en[1]), .DP_CLK_DIV5(en[0]), .HB3_COEF_TABLE(hb3_tab));
    txifc_src_model txifc_src_model_inst (.clk(clock), .in_ready(in_ready),
        .in_valid(in_valid), .in_i(in_i), .in_q(in_q));

    // consumer: records each popped word; random stalls exercise the two-entry buffer
    always @(posedge clock) begin
        if (rstn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
            outq.push_back({out_i, out_q});
        out_ready <= (rdy_mode == 2) ? 1'b0 : (rdy_mode == 1 ? 1'($random(seed)) : 1'b1);
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] d;
        rd(a, d);
        `CHK(nm, ex, d)
    endtask

    function automatic logic [31:0] cw(int ip, int tp, int g, int h1, int h2, int h3, int i5,
                                       int d5);
        return 32'(ip) << `TXIFC_CTRL_INTERP_LSB | 32'(tp) << `TXIFC_CTRL_TAPS_LSB |
            32'(g) << `TXIFC_CTRL_GAIN_LSB | 32'(h1) << `TXIFC_CTRL_HB1_LSB |
            32'(h2) << `TXIFC_CTRL_HB2_LSB | 32'(h3) << `TXIFC_CTRL_HB3_LSB |
            32'(i5) << `TXIFC_CTRL_FIVE_LSB | 32'(d5) << `TXIFC_CTRL_DIV5_BIT;
    endfunction

    // polyphase reference: history before the first sample is zero after reset
    function automatic logic [15:0] fir_out(int p, int l, int nt, int g, int n, bit use_q);
        longint acc;
        longint y;
        int tp;
        acc = 0;
        tp = (nt - p + l - 1) / l; // entries past the tap count never join the sum
        for (int j = 0; j < tp; j++)
            if (n - j >= 0)
                acc += longint'(cf[p + j * l]) * longint'(use_q ? xq[n - j] : xi[n - j]);
        y = (acc + (acc >>> 15)) >>> 15;
        case (g)
            0: y = y * 2;
            2: y = y >>> 1;
            3: y = y >>> 2;
            default: y = y;
        endcase
        if (y > 32767) y = 32767;
        if (y < -32768) y = -32768;
        return y[15:0];
    endfunction

    task automatic cfg_case(int ip, int tp, int h1, int h2, int h3, int i5, int d5, int rate);
        logic [31:0] d;
        logic [3:0] st;
        wr(`TXIFC_OFS_CTRL, cw(ip, tp, 1, h1, h2, h3, i5, d5));
        wr(`TXIFC_OFS_RATE, 32'(rate)); // some rows break the limits on purpose
        rd(`TXIFC_OFS_STATUS, d);
        st = {rate < 30720 || rate > 491520, !(ip inside {0, 1, 2, 4}),
              20 * (tp + 1) * rate > 20000000, i5 == 5 && (h2 == 2 || h3 == 2)};
        `CHK("status", {27'h0, st, 1'b0}, d)
        `CHK("enables", {h1 == 2, h2 == 2 && i5 != 5, h3 == 2 && i5 != 5, i5 == 5, d5 == 1}, en)
    endtask

    task automatic run_fir(int ip, int tp, int g, bit big);
        int l;
        logic [31:0] d;
        l = ip;
        do_reset();
        wr(`TXIFC_OFS_CTRL, cw(ip, tp, g, 1, 1, 1, 1, 0));
        wr(`TXIFC_OFS_RATE, 32'd122880);
        wr(`TXIFC_OFS_CADDR, 32'h0);
        for (int k = 0; k < 80; k++) begin
            cf[k] = big ? 16'sh7FFF : 16'($random(seed) % 3000);
            wr(`TXIFC_OFS_CDATA, {16'h0000, cf[k]});
        end
        xi.delete();
        xq.delete();
        outq.delete();
        rdy_mode = 1;
        for (int n = 0; n < 6; n++) begin
            xi.push_back(16'($random(seed)));
            xq.push_back(big ? -xi[n] : 16'($random(seed)));
            txifc_src_model_inst.send(xi[n], xq[n], $random(seed) & 3);
        end
        for (int w = 0; w < 4000 && outq.size() < 6 * l; w++) @(posedge clock);
        `CHK("out count", 6 * l, outq.size())
        for (int n = 0; n < 6; n++)
            for (int p = 0; p < l; p++) begin
                `CHK("fir i", fir_out(p, l, 20 * (tp + 1), g, n, 0), outq[n * l + p][31:16])
                `CHK("fir q", fir_out(p, l, 20 * (tp + 1), g, n, 1), outq[n * l + p][15:0])
            end
        if (big) begin
            rd(`TXIFC_OFS_STATUS, d);
            `CHK("sat flag", 1'b1, d[0])
            wr(`TXIFC_OFS_STATUS, 32'h1);
            rd(`TXIFC_OFS_STATUS, d);
            `CHK("sat cleared", 1'b0, d[0])
        end
        $display("test fir interp %0d taps %0d gain %0d done", ip, 20 * (tp + 1), g);
    endtask

    initial begin
        int s0;
        do_reset();
        chk_rd(`TXIFC_OFS_CTRL, `TXIFC_CTRL_RESET, "ctrl reset");
        chk_rd(`TXIFC_OFS_RATE, 32'(`TXIFC_RATE_RESET), "rate reset");
        chk_rd(`TXIFC_OFS_STATUS, 32'h0, "status reset");
        chk_rd(8'h14, 32'h0, "unmapped");
        `CHK("third half-band taps", {4'd1, 4'd4, 4'd6, 4'd4, 4'd1}, hb3_tab)
        wr(`TXIFC_OFS_CTRL, 32'hFFFE2AA0);
        chk_rd(`TXIFC_OFS_CTRL, 32'h00002AA0, "ctrl upper bits");
        $display("test reset values done");
        cfg_case(1, 0, 2, 2, 2, 1, 0, 491520);
        cfg_case(0, 3, 1, 2, 1, 5, 1, 491520);
        cfg_case(3, 1, 1, 1, 1, 1, 0, 30719);
        cfg_case(4, 2, 1, 1, 2, 5, 0, 30720);
        $display("test stage settings done");
        // bypass with the consumer held off: two words buffered, the third waits
        do_reset();
        xi.delete();
        xq.delete();
        outq.delete();
        for (int n = 0; n < 4; n++) begin
            xi.push_back(16'($random(seed)));
            xq.push_back(16'($random(seed)));
        end
        rdy_mode = 2;
        s0 = txifc_src_model_inst.sent;
        fork
            for (int n = 0; n < 4; n++) txifc_src_model_inst.send(xi[n], xq[n], 0);
        join_none
        repeat (30) @(posedge clock);
        `CHK("taken while full", 3, txifc_src_model_inst.sent - s0)
        `CHK("ready while full", 1'b0, in_ready)
        rdy_mode = 1;
        for (int w = 0; w < 500 && outq.size() < 4; w++) @(posedge clock);
        for (int n = 0; n < 4; n++)
            `CHK("bypass word", {xi[n], xq[n]}, outq[n])
        $display("test bypass stall done");
        run_fir(1, 0, 1, 1'b0);
        run_fir(2, 1, 0, 1'b0);
        run_fir(4, 3, 3, 1'b0);
        run_fir(4, 2, 2, 1'b0);
        run_fir(1, 0, 0, 1'b1);
        close_out();
    end

    // watchdog: the tests need well under this span
    initial begin
        #800000;
        failures++;
        $display("watchdog expired");
        close_out();
    end
endmodule
